// ---- cvf_pkg.sv ----
// shared constants for the converter event flag block
package cvf_pkg;

  // register port geometry
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned NUM_CMD         = 16;

  // register offsets on the plain register port
  localparam logic [7:0]  OFS_EVENT_FLAGS = 8'h09;
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0A;

  // field positions inside the flag register
  localparam int unsigned BIT_ABORT_DONE  = 7;
  localparam int unsigned BIT_OVERRUN     = 6;

  // implemented bits, others read as zero
  localparam logic [7:0]  FLAGS_IMPL      = 8'hC0;

  // values after reset
  localparam logic [7:0]  FLAGS_RST       = 8'h00;
  localparam logic [7:0]  MASK_RST        = 8'h00;
  localparam logic [7:0]  RDATA_RST       = 8'h00;

  // read data follows a read strobe by this many cycles
  localparam int unsigned RD_LATENCY      = 1;

endpackage : cvf_pkg

// ---- cvf_overrun_det.sv ----
// overrun detection of the per-command done flags and end-of-list flag
`timescale 1ns/100ps

module cvf_overrun_det
  import cvf_pkg::*;
(
  // mode selection
  input  wire logic                 result_buffer_mode,
  // current flag state
  input  wire logic [NUM_CMD-1:1]   per_command_done_flags,
  input  wire logic                 end_of_list_flag,
  // flag set requests from command execution
  input  wire logic [NUM_CMD-1:1]   cmd_flag_set,
  input  wire logic                 eol_flag_set,
  // first result from the top of a list being stored
  input  wire logic                 first_result_store,
  // result
  output logic                      overrun_hit
);

  logic [NUM_CMD-1:1] bit_clash;   // flag set again while still set
  logic               dbl_hit;     // double buffer detection
  logic               sgl_hit;     // single buffer detection

  // one comparator per command flag
  genvar gi;
  generate
    for (gi = 1; gi < NUM_CMD; gi++)
    begin : g_clash
      assign bit_clash[gi] = per_command_done_flags[gi] & cmd_flag_set[gi];
    end
  endgenerate

  // double buffer: any flag or end-of-list hit while still set
  assign dbl_hit = (|bit_clash) | (end_of_list_flag & eol_flag_set);

  // single buffer: only stale command flags at first store count,
  // end-of-list is never looked at here
  assign sgl_hit = first_result_store & (|per_command_done_flags);

  // mode mux
  always_comb
  begin
    if (result_buffer_mode)
      overrun_hit = dbl_hit;
    else
      overrun_hit = sgl_hit;
  end

endmodule : cvf_overrun_det

// ---- cvf_event_flags.sv ----
// converter event flag register with abort-done and overrun flags
`timescale 1ns/100ps

module cvf_event_flags
  import cvf_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // register port
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [DATA_W-1:0]    reg_rdata,
  // converter control levels
  input  wire logic                 conv_enable,
  input  wire logic                 converter_soft_reset,
  input  wire logic                 result_buffer_mode,
  input  wire logic                 restart_with_abort,
  input  wire logic                 stop_in_wait,
  // low-power entry requests
  input  wire logic                 stop_entry,
  input  wire logic                 wait_entry,
  // sequencer events, one-cycle pulses
  input  wire logic                 abort_executed,
  input  wire logic                 abort_by_hw,
  input  wire logic                 last_cmd_active,
  input  wire logic [NUM_CMD-1:1]   cmd_flag_set,
  input  wire logic                 eol_flag_set,
  input  wire logic                 first_result_store,
  // current conversion flag state
  input  wire logic [NUM_CMD-1:1]   per_command_done_flags,
  input  wire logic                 end_of_list_flag,
  // interrupt
  output logic                      irq
);

  logic [DATA_W-1:0] flags_ff;       // converter_event_flags
  logic [DATA_W-1:0] nxt_flags;
  logic [DATA_W-1:0] mask_ff;        // interrupt mask
  logic [DATA_W-1:0] rdata_ff;       // registered read data
  logic [DATA_W-1:0] nxt_rdata;
  logic              irq_ff;         // registered interrupt level
  logic              wr_flags;       // write hits flag register
  logic              wr_mask;        // write hits mask register
  logic [DATA_W-1:0] clr_vec;        // write-one clear bits
  logic [DATA_W-1:0] set_vec;        // hardware set bits
  logic              lowpower_abort; // abort issued to enter low power
  logic              last_cmd_abort; // abort during last command w/ restart
  logic              abort_set;      // qualified abort-done event
  logic              overrun_hit;    // overrun detected this cycle

  // address decode
  assign wr_flags = reg_wr & (reg_addr == OFS_EVENT_FLAGS);
  assign wr_mask  = reg_wr & (reg_addr == OFS_IRQ_MASK);

  // only implemented bits may be cleared
  assign clr_vec = wr_flags ? (reg_wdata & FLAGS_IMPL) : '0;

  // abort qualification: hardware aborts for stop, or for wait
  // with stop_in_wait set, do not raise the flag
  assign lowpower_abort = abort_by_hw & (stop_entry | (wait_entry & stop_in_wait));
  assign last_cmd_abort = last_cmd_active & restart_with_abort;
  assign abort_set      = abort_executed & ~lowpower_abort & ~last_cmd_abort;

  // overrun detector, mode dependent
  cvf_overrun_det u_overrun_det (
    .result_buffer_mode     (result_buffer_mode),
    .per_command_done_flags (per_command_done_flags),
    .end_of_list_flag       (end_of_list_flag),
    .cmd_flag_set           (cmd_flag_set),
    .eol_flag_set           (eol_flag_set),
    .first_result_store     (first_result_store),
    .overrun_hit            (overrun_hit)
  );

  // hardware set vector
  always_comb
  begin
    set_vec                 = '0;
    set_vec[BIT_ABORT_DONE] = abort_set;
    set_vec[BIT_OVERRUN]    = overrun_hit;
  end

  // flag next state; set applied after clear so no event is lost
  always_comb
  begin
    if (!conv_enable || converter_soft_reset)
      nxt_flags = FLAGS_RST;
    else
      nxt_flags = ((flags_ff & ~clr_vec) | set_vec) & FLAGS_IMPL;
  end

  // flag register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_ff <= FLAGS_RST;
    else
      flags_ff <= nxt_flags;
  end

  // mask register, same layout as the flags
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_ff <= MASK_RST;
    else if (wr_mask)
      mask_ff <= reg_wdata & FLAGS_IMPL;
  end

  // read mux; unmapped offsets answer zero
  always_comb
  begin
    nxt_rdata = RDATA_RST;
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_EVENT_FLAGS: nxt_rdata = flags_ff;
        OFS_IRQ_MASK:    nxt_rdata = mask_ff;
        default:         nxt_rdata = RDATA_RST;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= RDATA_RST;
    else
      rdata_ff <= nxt_rdata;
  end

  // interrupt level; one cycle behind the flags, keeps irq a flop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(flags_ff & mask_ff);
  end

  // outputs straight from flops
  assign reg_rdata = rdata_ff;
  assign irq       = irq_ff;

  // ---------------- assertions ----------------
  // a clean cycle: block active and not in soft reset
  sequence seq_active;
    conv_enable && !converter_soft_reset;
  endsequence

  // write one to the abort-done bit, no competing set
  sequence seq_abort_clear;
    seq_active ##0 wr_flags && reg_wdata[BIT_ABORT_DONE] && !abort_set;
  endsequence

  // read of the flag register
  sequence seq_flag_read;
    reg_rd && (reg_addr == OFS_EVENT_FLAGS);
  endsequence

  chk_disable_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !conv_enable |=> (flags_ff == FLAGS_RST))
    else $error("flags not cleared while converter disabled");

  chk_soft_reset_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    converter_soft_reset |=> (flags_ff == FLAGS_RST))
    else $error("flags not cleared by soft reset");

  chk_write_one_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_abort_clear |=> !flags_ff[BIT_ABORT_DONE])
    else $error("write one did not clear abort flag");

  chk_write_zero_keeps: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 (wr_flags && !reg_wdata[BIT_OVERRUN] && flags_ff[BIT_OVERRUN])
    |=> flags_ff[BIT_OVERRUN])
    else $error("write zero changed overrun flag");

  chk_write_never_sets: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (wr_flags && !flags_ff[BIT_OVERRUN] && !overrun_hit)
    |=> !flags_ff[BIT_OVERRUN])
    else $error("software write set overrun flag");

  chk_abort_sets: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 abort_executed && !abort_by_hw && !last_cmd_active
    |=> flags_ff[BIT_ABORT_DONE] [*1] ##1 (flags_ff[BIT_ABORT_DONE] || !$past(conv_enable)
        || $past(converter_soft_reset) || $past(wr_flags)))
    else $error("abort done flag not set or lost");

  chk_lowpower_abort: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (abort_executed && abort_by_hw && (stop_entry || (wait_entry && stop_in_wait))
     && !flags_ff[BIT_ABORT_DONE])
    |=> !flags_ff[BIT_ABORT_DONE])
    else $error("abort flag set by low-power abort");

  chk_last_cmd_abort: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (abort_executed && last_cmd_active && restart_with_abort
     && !flags_ff[BIT_ABORT_DONE])
    |=> !flags_ff[BIT_ABORT_DONE])
    else $error("abort flag set on last command restart");

  chk_double_overrun: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 result_buffer_mode
    && ((|(per_command_done_flags & cmd_flag_set)) || (end_of_list_flag && eol_flag_set))
    |=> flags_ff[BIT_OVERRUN])
    else $error("double buffer overrun not flagged");

  chk_single_overrun: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 !result_buffer_mode && first_result_store && (|per_command_done_flags)
    |=> flags_ff[BIT_OVERRUN])
    else $error("single buffer overrun not flagged");

  chk_single_no_eol: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!result_buffer_mode && !first_result_store && !flags_ff[BIT_OVERRUN])
    |=> !flags_ff[BIT_OVERRUN])
    else $error("single buffer flagged overrun outside first store");

  chk_set_beats_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 wr_flags && reg_wdata[BIT_OVERRUN] && overrun_hit
    |=> flags_ff[BIT_OVERRUN])
    else $error("same-cycle clear lost an overrun event");

  chk_flag_readback: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_flag_read |=> (reg_rdata == $past(flags_ff)) ##1 (reg_rdata == RDATA_RST
                      || $past(reg_rd)))
    else $error("flag read data wrong or held too long");

  chk_irq_follows: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (|(flags_ff & mask_ff)) |=> irq)
    else $error("interrupt not raised for unmasked flag");

  // the opposite direction, so a stuck-high irq is caught too
  chk_irq_quiet: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !(|(flags_ff & mask_ff)) |=> !irq)
    else $error("interrupt raised with no unmasked flag");

  // read of the mask register
  sequence seq_mask_read;
    reg_rd && (reg_addr == OFS_IRQ_MASK);
  endsequence

  // mask read data is the mask as it stood at the strobe
  chk_mask_readback: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_mask_read |=> (reg_rdata == $past(mask_ff)))
    else $error("mask read data wrong");

  // no strobe, no data: the port idles at zero
  chk_rdata_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == RDATA_RST))
    else $error("read data not idle after a cycle without strobe");

  // write one clears the overrun bit when no overrun competes
  chk_overrun_clears: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 wr_flags && reg_wdata[BIT_OVERRUN] && !overrun_hit
    |=> !flags_ff[BIT_OVERRUN])
    else $error("write one did not clear overrun flag");

  // zero written to a set abort bit leaves it set
  chk_abort_w0_keeps: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 (wr_flags && !reg_wdata[BIT_ABORT_DONE] && flags_ff[BIT_ABORT_DONE])
    |=> flags_ff[BIT_ABORT_DONE])
    else $error("write zero changed abort flag");

  // the abort bit only rises on a qualified abort event, never on a write
  chk_abort_only_event: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!abort_set && !flags_ff[BIT_ABORT_DONE])
    |=> !flags_ff[BIT_ABORT_DONE])
    else $error("abort flag rose without an abort event");

  // the overrun bit only rises when the detector fires
  chk_overrun_only_hit: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!overrun_hit && !flags_ff[BIT_OVERRUN])
    |=> !flags_ff[BIT_OVERRUN])
    else $error("overrun flag rose without an overrun");

  // double buffer: no clash, no overrun
  chk_double_no_clash: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (result_buffer_mode && !(|(per_command_done_flags & cmd_flag_set))
     && !(end_of_list_flag && eol_flag_set) && !flags_ff[BIT_OVERRUN])
    |=> !flags_ff[BIT_OVERRUN])
    else $error("double buffer overrun without a clash");

  // single buffer: clean command flags mean no overrun at any store
  chk_single_clean_store: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!result_buffer_mode && !(|per_command_done_flags) && !flags_ff[BIT_OVERRUN])
    |=> !flags_ff[BIT_OVERRUN])
    else $error("single buffer overrun with clean flags");

  // same-cycle abort and write one: the abort survives
  chk_abort_beats_clear: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_active ##0 wr_flags && reg_wdata[BIT_ABORT_DONE] && abort_set
    |=> flags_ff[BIT_ABORT_DONE])
    else $error("same-cycle clear lost an abort event");

  // unmasked abort event: flag one cycle later, irq one more
  sequence seq_abort_event;
    seq_active ##0 abort_set && mask_ff[BIT_ABORT_DONE] && !wr_mask;
  endsequence

  chk_abort_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    seq_abort_event |=> flags_ff[BIT_ABORT_DONE] ##1 irq)
    else $error("abort event did not reach the interrupt");

  // soft reset and disable both leave irq low two edges later
  chk_soft_reset_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    converter_soft_reset |-> ##2 !irq)
    else $error("interrupt survived soft reset");

  chk_disable_irq: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !conv_enable |-> ##2 !irq)
    else $error("interrupt survived converter disable");

endmodule : cvf_event_flags

// ---- test_cvf_event_flags.sv ----
// self-checking bench for the converter event flag register
`timescale 1ns/100ps

module test_cvf_event_flags
  import cvf_pkg::*;
;
  // clock, reset and register port
  logic                 core_clk, rst_n, reg_wr, reg_rd, irq;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata, reg_rdata;
  // converter levels and sequencer events
  logic                 conv_enable, converter_soft_reset, result_buffer_mode;
  logic                 restart_with_abort, stop_in_wait, stop_entry, wait_entry;
  logic                 abort_executed, abort_by_hw, last_cmd_active;
  logic                 eol_flag_set, first_result_store, end_of_list_flag;
  logic [NUM_CMD-1:1]   cmd_flag_set, per_command_done_flags;
  // scoreboard counters
  int                   failures, checks_done;
  // abort qualifiers: hw, stop, wait, stop-in-wait, last cmd, restart
  logic [5:0]           sup [6] = '{6'h30, 6'h2C, 6'h28, 6'h03, 6'h02, 6'h24};
  logic [7:0]           sup_exp [6] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h80};

  cvf_event_flags i_dut (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_enable, .converter_soft_reset, .result_buffer_mode, .restart_with_abort,
    .stop_in_wait, .stop_entry, .wait_entry, .abort_executed, .abort_by_hw,
    .last_cmd_active, .cmd_flag_set, .eol_flag_set, .first_result_store,
    .per_command_done_flags, .end_of_list_flag, .irq
  );

  // free-running 250 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // case equality so an unknown never counts as a match
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
    @(posedge core_clk);
  endtask : rd

  // irq lags the flags by a cycle, so give it one edge
  task automatic ckirq(input logic e);
    @(posedge core_clk);
    #1;
    chk("irq", {7'h00, e}, {7'h00, irq});
    @(posedge core_clk);
  endtask : ckirq

  // single-cycle sequencer event pulses
  task automatic ev(input logic ab, input logic [15:1] cs, input logic es, input logic fr);
    abort_executed     <= ab;
    cmd_flag_set       <= cs;
    eol_flag_set       <= es;
    first_result_store <= fr;
    @(posedge core_clk);
    abort_executed     <= 1'b0;
    cmd_flag_set       <= '0;
    eol_flag_set       <= 1'b0;
    first_result_store <= 1'b0;
  endtask : ev

  // overrun case: mode, stale flags, set pulses, expected register
  task automatic ov(input logic m, input logic [15:1] df, input logic ef,
                    input logic [15:1] cs, input logic es, input logic fr,
                    input logic [7:0] exp);
    result_buffer_mode     <= m;
    per_command_done_flags <= df;
    end_of_list_flag       <= ef;
    ev(1'b0, cs, es, fr);
    rd(OFS_EVENT_FLAGS, exp, "overrun");
    wr(OFS_EVENT_FLAGS, 8'hFF);
  endtask : ov

  // single exit point for normal end and watchdog
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // watchdog well beyond the roughly 120 cycles the run needs
  initial
  begin
    repeat (3000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {converter_soft_reset, result_buffer_mode, restart_with_abort, stop_in_wait} = '0;
    {stop_entry, wait_entry, abort_executed, abort_by_hw, last_cmd_active} = '0;
    {cmd_flag_set, eol_flag_set, first_result_store, per_command_done_flags} = '0;
    end_of_list_flag = 1'b0;
    conv_enable = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(OFS_EVENT_FLAGS, FLAGS_RST, "flags rst");
    rd(OFS_IRQ_MASK, MASK_RST, "mask rst");
    wr(OFS_IRQ_MASK, 8'hFF);
    rd(OFS_IRQ_MASK, 8'hC0, "mask bits");
    wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'h00, "unmapped");
    wr(OFS_EVENT_FLAGS, 8'hFF);
    rd(OFS_EVENT_FLAGS, 8'h00, "w1 no set");
    ev(1'b1, '0, 1'b0, 1'b0);
    rd(OFS_EVENT_FLAGS, 8'h80, "abort");
    ckirq(1'b1);
    wr(OFS_IRQ_MASK, 8'h40);
    ckirq(1'b0);
    wr(OFS_IRQ_MASK, 8'hC0);
    ckirq(1'b1);
    wr(OFS_EVENT_FLAGS, 8'h40);
    rd(OFS_EVENT_FLAGS, 8'h80, "w0 keeps");
    wr(OFS_EVENT_FLAGS, 8'h80);
    rd(OFS_EVENT_FLAGS, 8'h00, "w1c");
    ckirq(1'b0);
    // set and clear in the same cycle
    abort_executed <= 1'b1;
    wr(OFS_EVENT_FLAGS, 8'h80);
    abort_executed <= 1'b0;
    rd(OFS_EVENT_FLAGS, 8'h80, "set wins");
    converter_soft_reset <= 1'b1;
    @(posedge core_clk);
    converter_soft_reset <= 1'b0;
    rd(OFS_EVENT_FLAGS, 8'h00, "soft rst");
    ev(1'b1, '0, 1'b0, 1'b0);
    conv_enable <= 1'b0;
    @(posedge core_clk);
    rd(OFS_EVENT_FLAGS, 8'h00, "disabled");
    ev(1'b1, '0, 1'b0, 1'b0);
    conv_enable <= 1'b1;
    rd(OFS_EVENT_FLAGS, 8'h00, "event off");
    // abort qualifier table
    for (int i = 0; i < 6; i++)
    begin
      {abort_by_hw, stop_entry, wait_entry, stop_in_wait, last_cmd_active,
       restart_with_abort} <= sup[i];
      ev(1'b1, '0, 1'b0, 1'b0);
      rd(OFS_EVENT_FLAGS, sup_exp[i], "abort qual");
      wr(OFS_EVENT_FLAGS, 8'hFF);
    end
    {abort_by_hw, stop_entry, wait_entry, stop_in_wait, last_cmd_active,
     restart_with_abort} <= 6'h00;
    ov(1'b1, 15'h0001, 1'b0, 15'h0001, 1'b0, 1'b0, 8'h40);
    ov(1'b1, 15'h4000, 1'b0, 15'h4000, 1'b0, 1'b0, 8'h40);
    ov(1'b1, 15'h0001, 1'b0, 15'h0002, 1'b0, 1'b0, 8'h00);
    ov(1'b1, 15'h0000, 1'b1, 15'h0000, 1'b1, 1'b0, 8'h40);
    ov(1'b1, 15'h0010, 1'b0, 15'h0000, 1'b0, 1'b1, 8'h00);
    ov(1'b0, 15'h0000, 1'b1, 15'h0000, 1'b1, 1'b0, 8'h00);
    ov(1'b0, 15'h0001, 1'b0, 15'h0001, 1'b0, 1'b0, 8'h00);
    ov(1'b0, 15'h0004, 1'b0, 15'h0000, 1'b0, 1'b1, 8'h40);
    ov(1'b0, 15'h0000, 1'b0, 15'h7FFF, 1'b0, 1'b1, 8'h00);
    // overrun kept by a zero write, then re-set beating its own clear
    result_buffer_mode     <= 1'b1;
    per_command_done_flags <= 15'h0001;
    ev(1'b0, 15'h0001, 1'b0, 1'b0);
    wr(OFS_EVENT_FLAGS, 8'h80);
    rd(OFS_EVENT_FLAGS, 8'h40, "ovr w0 keeps");
    cmd_flag_set <= 15'h0001;
    wr(OFS_EVENT_FLAGS, 8'h40);
    cmd_flag_set <= '0;
    rd(OFS_EVENT_FLAGS, 8'h40, "ovr set wins");
    wr(OFS_EVENT_FLAGS, 8'hFF);
    per_command_done_flags <= '0;
    rd(OFS_EVENT_FLAGS, 8'h00, "ovr w1c");
    wrap_up();
  end

endmodule : test_cvf_event_flags
